//--- rtl/rgi_pkg.sv
// package of shared types and constants for the rod group interlock
package rgi_pkg;
    localparam int NUM_GROUPS = 8;
    localparam int NUM_SAFETY = 4;
    localparam int NUM_REG = 3;
    localparam int POS_W = 8;
    // position thresholds in percent of full withdrawal
    localparam int LOW_PCT = 25;
    localparam int HIGH_PCT = 75;
    localparam logic [POS_W-1:0] POS_FULL = 8'hff;
    localparam logic [POS_W-1:0] LOW_THRESH = POS_W'((LOW_PCT * 255) / 100);
    localparam logic [POS_W-1:0] HIGH_THRESH = POS_W'((HIGH_PCT * 255) / 100);
    // group indices, zero based (group 1 at index 0)
    localparam int REG_FIRST = 4;
    localparam int SHAPING_IDX = 7;
    localparam logic [NUM_GROUPS-1:0] SAFETY_MASK = 8'h0f;
    localparam logic [NUM_GROUPS-1:0] AUTO_MASK = 8'h70;
    localparam logic [NUM_GROUPS-1:0] RST_GROUPS = 8'h00;

    typedef enum logic [1:0] {
        RGI_MODE_MANUAL,
        RGI_MODE_AUTO,
        RGI_MODE_BYPASS
    } rgi_mode_t;

    typedef struct packed {
        logic prot_inhibit;
        logic sup_inhibit;
        logic flux_out_inhibit;
    } rgi_inhibit_t;

    typedef struct packed {
        logic [1:0] low_voltage_release_feed;
        logic [1:0] thyristor_gate_feed;
        logic [1:0] holding_feed;
    } rgi_trip_t;

    typedef struct packed {
        logic [NUM_GROUPS-1:0] insert;
        logic [NUM_GROUPS-1:0] withdraw;
    } rgi_cmd_t;
endpackage

//--- rtl/rgi_thresh.sv
// threshold detectors (25 percent, 75 percent, full out) on one averaged regulating group position
`timescale 1ns/1ps
module rgi_thresh #(
    parameter int POS_W = rgi_pkg::POS_W
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [POS_W-1:0] avg_pos_i,
    output logic above_low_o,
    output logic above_high_o,
    output logic full_out_o
);
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            above_low_o <= 1'b0;
            above_high_o <= 1'b0;
            full_out_o <= 1'b0;
        end else begin
            above_low_o <= (avg_pos_i >= rgi_pkg::LOW_THRESH);
            above_high_o <= (avg_pos_i >= rgi_pkg::HIGH_THRESH);
            full_out_o <= (avg_pos_i == rgi_pkg::POS_FULL);
        end
    end
endmodule

//--- rtl/rgi_interlock.sv
// rod group sequence interlock: mode, enables, command gating, trips
`timescale 1ns/1ps
module rgi_interlock #(
    parameter int NUM_GROUPS = rgi_pkg::NUM_GROUPS,
    parameter int POS_W = rgi_pkg::POS_W
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic auto_req_i,
    input wire logic bypass_req_i,
    input wire logic [NUM_GROUPS-1:0] group_sel_i,
    input wire logic single_rod_sel_i,
    input wire logic aux_transfer_done_i,
    input wire rgi_pkg::rgi_cmd_t manual_cmd_i,
    input wire rgi_pkg::rgi_cmd_t auto_cmd_i,
    input wire rgi_pkg::rgi_inhibit_t inhibit_i,
    input wire rgi_pkg::rgi_trip_t trip_i,
    input wire logic [rgi_pkg::NUM_REG*POS_W-1:0] reg_avg_pos_i,
    input wire logic [NUM_GROUPS-1:0] safety_withdrawn_i,
    input wire logic pos_src_rel_i,
    input wire logic [POS_W-1:0] abs_pos_i,
    input wire logic [POS_W-1:0] rel_pos_i,
    input wire logic [NUM_GROUPS-1:0] limit_in_i,
    input wire logic [NUM_GROUPS-1:0] limit_out_i,
    output rgi_pkg::rgi_cmd_t drive_cmd_o,
    output rgi_pkg::rgi_mode_t mode_o,
    output logic [NUM_GROUPS-1:0] group_enable_o,
    output logic [NUM_GROUPS-1:0] under_control_o,
    output logic out_of_seq_ind_o,
    output logic select_reject_o,
    output logic [POS_W-1:0] pos_ind_o,
    output logic [NUM_GROUPS-1:0] full_in_ind_o,
    output logic [NUM_GROUPS-1:0] full_out_ind_o,
    output logic ac_feed_power_o,
    output logic dc_power_o
);
    localparam int NR = rgi_pkg::NUM_REG;
    localparam int RF = rgi_pkg::REG_FIRST;

    // more than one bit set
    function automatic logic multi_hot(input logic [NUM_GROUPS-1:0] v);
        return (v & (v - NUM_GROUPS'(1))) != '0;
    endfunction

    // true only when the moving set is one adjacent pair whose overlap window is open
    function automatic logic pair_allowed(input logic [NR-1:0] moving,
                                          input logic [NR-2:0] window);
        logic ok;
        ok = 1'b0;
        for (int k = 0; k < NR - 1; k++) begin
            if (moving == (NR'(3) << k)) begin
                ok = window[k];
            end
        end
        return ok;
    endfunction

    rgi_pkg::rgi_mode_t mode_r;
    rgi_pkg::rgi_mode_t mode_nxt;
    logic [NR-1:0] above_low;
    logic [NR-1:0] above_high;
    logic [NR-1:0] full_out;
    logic mode_lock;
    logic trip_active;
    logic [NUM_GROUPS-1:0] reg_en;
    logic [NUM_GROUPS-1:0] sel_valid;
    logic safety_all_out;
    logic sel_multi;
    logic single_refused;
    logic ac_trip;
    logic dc_trip;
    logic [NR-1:0] reg_move;
    logic [NR-2:0] pair_window;
    rgi_pkg::rgi_cmd_t gated;

    genvar g;
    generate
        for (g = 0; g < NR; g++) begin : g_thr
            rgi_thresh #(.POS_W(POS_W)) u_thr (
                .ref_clk_i(ref_clk_i),
                .rst_n_i(rst_n_i),
                .avg_pos_i(reg_avg_pos_i[g*POS_W +: POS_W]),
                .above_low_o(above_low[g]),
                .above_high_o(above_high[g]),
                .full_out_o(full_out[g])
            );
        end
    endgenerate

    // overlap windows, one per adjacent regulating pair: leader past 75 percent,
    // follower still inside its first quarter
    generate
        for (g = 0; g < NR - 1; g++) begin : g_pair
            assign pair_window[g] = above_high[g] & ~above_low[g+1];
        end
    endgenerate

    // mode selection; a protection or supervisory inhibit freezes the current mode
    assign mode_lock = inhibit_i.prot_inhibit | inhibit_i.sup_inhibit;
    always_comb begin
        mode_nxt = rgi_pkg::RGI_MODE_MANUAL;
        if (auto_req_i) begin
            mode_nxt = rgi_pkg::RGI_MODE_AUTO;
        end else if (bypass_req_i) begin
            mode_nxt = rgi_pkg::RGI_MODE_BYPASS;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_r <= rgi_pkg::RGI_MODE_MANUAL;
        end else if (!mode_lock) begin
            mode_r <= mode_nxt;
        end
    end

    // sequence enables: next group only once the previous passed 75 percent on withdraw,
    // and a group stays enabled while its own position is past 25 percent and short of full out
    assign safety_all_out = &safety_withdrawn_i[rgi_pkg::NUM_SAFETY-1:0];
    always_comb begin
        reg_en = '0;
        for (int i = 0; i < NR; i++) begin
            if (i == 0) begin
                reg_en[RF+i] = safety_all_out;
            end else begin
                reg_en[RF+i] = safety_all_out & above_high[i-1];
            end
            // a group that has started moving keeps its enable to allow insertion
            if (above_low[i] & ~full_out[i]) begin
                reg_en[RF+i] = reg_en[RF+i] | safety_all_out;
            end
        end
    end

    // one group selected at a time; a safety group also needs aux transfer
    assign sel_multi = multi_hot(group_sel_i);
    // single rod control stays with the operator, so it is refused while the controller rules
    assign single_refused = single_rod_sel_i & (mode_r == rgi_pkg::RGI_MODE_AUTO);
    always_comb begin
        sel_valid = '0;
        if (!sel_multi) begin
            sel_valid = group_sel_i;
            sel_valid = sel_valid & ~(rgi_pkg::SAFETY_MASK & {NUM_GROUPS{~aux_transfer_done_i}});
        end
    end

    // feeds run in parallel, so a method acts only once both of its feeds are gone
    assign ac_trip = (trip_i.low_voltage_release_feed == 2'b00);
    assign dc_trip = (trip_i.thyristor_gate_feed == 2'b00)
        && (trip_i.holding_feed == 2'b00);
    assign trip_active = ac_trip | dc_trip;

    // command gating, combinational ahead of the output register
    always_comb begin
        gated.insert = '0;
        gated.withdraw = '0;
        case (mode_r)
            rgi_pkg::RGI_MODE_AUTO: begin
                // auto acts only on 5-7; the shaping group stays manual and safety groups get no command
                gated.insert = auto_cmd_i.insert & rgi_pkg::AUTO_MASK & reg_en;
                gated.withdraw = auto_cmd_i.withdraw & rgi_pkg::AUTO_MASK & reg_en;
                gated.insert[rgi_pkg::SHAPING_IDX] = manual_cmd_i.insert[rgi_pkg::SHAPING_IDX]
                    & group_sel_i[rgi_pkg::SHAPING_IDX] & ~sel_multi & ~single_refused;
                gated.withdraw[rgi_pkg::SHAPING_IDX] =
                    manual_cmd_i.withdraw[rgi_pkg::SHAPING_IDX]
                    & group_sel_i[rgi_pkg::SHAPING_IDX] & ~sel_multi & ~single_refused;
            end
            rgi_pkg::RGI_MODE_MANUAL: begin
                gated.insert = manual_cmd_i.insert & sel_valid
                    & (reg_en | ~rgi_pkg::AUTO_MASK);
                gated.withdraw = manual_cmd_i.withdraw & sel_valid
                    & (reg_en | ~rgi_pkg::AUTO_MASK);
            end
            rgi_pkg::RGI_MODE_BYPASS: begin
                // sequence enables skipped, still a single group only
                gated.insert = manual_cmd_i.insert & sel_valid;
                gated.withdraw = manual_cmd_i.withdraw & sel_valid;
            end
            default: begin
                gated.insert = '0;
                gated.withdraw = '0;
            end
        endcase
        // sequence fault monitor: three groups, or a pair outside its overlap window, never
        // reach the drives; bypass is the operator's deliberate way around it
        reg_move = gated.insert[RF +: NR] | gated.withdraw[RF +: NR];
        if (mode_r != rgi_pkg::RGI_MODE_BYPASS && multi_hot(NUM_GROUPS'(reg_move))
            && !pair_allowed(reg_move, pair_window)) begin
            gated.insert[RF +: NR] = '0;
            gated.withdraw[RF +: NR] = '0;
        end
        if (inhibit_i.flux_out_inhibit) begin
            gated.withdraw = '0;
        end
        if (mode_lock || trip_active) begin
            gated.insert = '0;
            gated.withdraw = '0;
        end
    end

    // output registers: commands and status
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drive_cmd_o <= '0;
            group_enable_o <= rgi_pkg::RST_GROUPS;
            under_control_o <= rgi_pkg::RST_GROUPS;
            mode_o <= rgi_pkg::RGI_MODE_MANUAL;
        end else begin
            drive_cmd_o <= gated;
            group_enable_o <= reg_en;
            under_control_o <= (mode_r == rgi_pkg::RGI_MODE_AUTO)
                ? (rgi_pkg::AUTO_MASK & reg_en) : sel_valid;
            mode_o <= mode_r;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_of_seq_ind_o <= 1'b0;
            select_reject_o <= 1'b0;
        end else begin
            out_of_seq_ind_o <= (mode_r == rgi_pkg::RGI_MODE_BYPASS);
            select_reject_o <= sel_multi | single_refused;
        end
    end

    // indication path
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_ind_o <= '0;
            full_in_ind_o <= '0;
            full_out_ind_o <= '0;
        end else begin
            pos_ind_o <= pos_src_rel_i ? rel_pos_i : abs_pos_i;
            full_in_ind_o <= limit_in_i;
            full_out_ind_o <= limit_out_i;
        end
    end

    // trip outputs; the shaping supply shares the same feeds as the others
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ac_feed_power_o <= 1'b0;
            dc_power_o <= 1'b0;
        end else begin
            ac_feed_power_o <= ~ac_trip;
            dc_power_o <= ~dc_trip;
        end
    end
endmodule

//--- tb/rgi_monitor.sv
// concurrent checks on the interlock's top ports
`timescale 1ns/1ps
module rgi_monitor (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic auto_req_i,
    input wire logic bypass_req_i,
    input wire logic [rgi_pkg::NUM_GROUPS-1:0] group_sel_i,
    input wire rgi_pkg::rgi_cmd_t manual_cmd_i,
    input wire rgi_pkg::rgi_inhibit_t inhibit_i,
    input wire rgi_pkg::rgi_trip_t trip_i,
    input wire logic pos_src_rel_i,
    input wire logic [rgi_pkg::POS_W-1:0] abs_pos_i,
    input wire logic [rgi_pkg::POS_W-1:0] rel_pos_i,
    input wire logic [rgi_pkg::NUM_GROUPS-1:0] limit_in_i,
    input wire logic [rgi_pkg::NUM_GROUPS-1:0] limit_out_i,
    input wire rgi_pkg::rgi_cmd_t drive_cmd_o,
    input wire rgi_pkg::rgi_mode_t mode_o,
    input wire logic select_reject_o,
    input wire logic [rgi_pkg::POS_W-1:0] pos_ind_o,
    input wire logic [rgi_pkg::NUM_GROUPS-1:0] full_in_ind_o,
    input wire logic [rgi_pkg::NUM_GROUPS-1:0] full_out_ind_o,
    input wire logic ac_feed_power_o,
    input wire logic dc_power_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [rgi_pkg::NUM_GROUPS-1:0] man_any;
    logic [rgi_pkg::NUM_GROUPS-1:0] drv_any;
    assign man_any = manual_cmd_i.insert | manual_cmd_i.withdraw;
    assign drv_any = drive_cmd_o.insert | drive_cmd_o.withdraw;
    a_inhibit_blocks_cmd:
        assert property (inhibit_i.prot_inhibit || inhibit_i.sup_inhibit |=> drive_cmd_o == '0)
        else $error("command passed while inhibited");
    a_flux_no_withdraw:
        assert property (inhibit_i.flux_out_inhibit |=> drive_cmd_o.withdraw == '0)
        else $error("withdraw passed under flux inhibit");
    a_ac_trip_cuts:
        assert property (trip_i.low_voltage_release_feed == 2'b00 |=> !ac_feed_power_o
            && drive_cmd_o == '0) else $error("ac trip did not remove power");
    a_dc_trip_cuts:
        assert property (trip_i.thyristor_gate_feed == 2'b00 && trip_i.holding_feed == 2'b00
            |=> !dc_power_o && drive_cmd_o == '0) else $error("dc trip did not remove power");
    a_bypass_refused:
        assert property ((auto_req_i && bypass_req_i && !inhibit_i.prot_inhibit
            && !inhibit_i.sup_inhibit)[*2] |=> mode_o == rgi_pkg::RGI_MODE_AUTO)
        else $error("bypass taken while auto requested");
    a_multi_select:
        assert property ($countones(group_sel_i) > 1 |=> select_reject_o)
        else $error("multiple group select not rejected");
    a_indicator_src:
        assert property (1'b1 |=> pos_ind_o == ($past(pos_src_rel_i) ? $past(rel_pos_i)
            : $past(abs_pos_i))) else $error("indicator shows wrong source");
    a_limit_copy:
        assert property (1'b1 |=> full_in_ind_o == $past(limit_in_i)
            && full_out_ind_o == $past(limit_out_i)) else $error("limit lamps wrong");
    a_shaping_manual:
        assert property (!man_any[7] |=> !drv_any[7]) else $error("shaping group moved unasked");
    a_safety_manual:
        assert property ((man_any & rgi_pkg::SAFETY_MASK) == '0
            |=> (drv_any & rgi_pkg::SAFETY_MASK) == '0) else $error("safety group moved unasked");
    c_auto: cover property (mode_o == rgi_pkg::RGI_MODE_AUTO);
    c_bypass: cover property (mode_o == rgi_pkg::RGI_MODE_BYPASS);
    c_reject: cover property (select_reject_o);
endmodule

//--- tb/rgi_panel_model.sv
// operator panel model: moves a lone selected safety group onto the auxiliary supply
`timescale 1ns/1ps
module rgi_panel_model (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [rgi_pkg::NUM_GROUPS-1:0] group_sel_i,
    output logic aux_transfer_done_o
);
    // transfer relays take a cycle; a multiple safety selection never transfers
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aux_transfer_done_o <= 1'b0;
        end else begin
            aux_transfer_done_o <= $countones(group_sel_i) == 1
                && |(group_sel_i & rgi_pkg::SAFETY_MASK);
        end
    end
endmodule

//--- tb/testbench.sv
// self-checking bench for the rod group interlock
`timescale 1ns/1ps
module testbench;
    logic ref_clk_i, rst_n_i, auto_req_i, bypass_req_i, single_rod_sel_i, aux_transfer_done_i;
    logic pos_src_rel_i, out_of_seq_ind_o, select_reject_o, ac_feed_power_o, dc_power_o;
    logic [7:0] group_sel_i, safety_withdrawn_i, limit_in_i, limit_out_i, group_enable_o;
    logic [7:0] under_control_o, full_in_ind_o, full_out_ind_o, abs_pos_i, rel_pos_i, pos_ind_o;
    logic [23:0] reg_avg_pos_i;
    rgi_pkg::rgi_cmd_t manual_cmd_i, auto_cmd_i, drive_cmd_o;
    rgi_pkg::rgi_inhibit_t inhibit_i;
    rgi_pkg::rgi_trip_t trip_i;
    rgi_pkg::rgi_mode_t mode_o;
    int err_total = 0, compares = 0, cyc = 0;
    logic [7:0] pos_tab [3] = '{8'h00, 8'hbe, 8'hbf};
    logic [7:0] en_tab [3] = '{8'h10, 8'h10, 8'h30};
    logic [5:0] trip_tab [5] = '{6'h3f, 6'h1f, 6'h0f, 6'h33, 6'h30};
    logic [1:0] pw_tab [5] = '{2'b11, 2'b11, 2'b01, 2'b11, 2'b10};
    rgi_interlock dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .auto_req_i(auto_req_i),
        .bypass_req_i(bypass_req_i), .group_sel_i(group_sel_i),
        .single_rod_sel_i(single_rod_sel_i), .aux_transfer_done_i(aux_transfer_done_i),
        .manual_cmd_i(manual_cmd_i), .auto_cmd_i(auto_cmd_i), .inhibit_i(inhibit_i),
        .trip_i(trip_i), .reg_avg_pos_i(reg_avg_pos_i), .safety_withdrawn_i(safety_withdrawn_i),
        .pos_src_rel_i(pos_src_rel_i), .abs_pos_i(abs_pos_i), .rel_pos_i(rel_pos_i),
        .limit_in_i(limit_in_i), .limit_out_i(limit_out_i), .drive_cmd_o(drive_cmd_o),
        .mode_o(mode_o), .group_enable_o(group_enable_o), .under_control_o(under_control_o),
        .out_of_seq_ind_o(out_of_seq_ind_o), .select_reject_o(select_reject_o),
        .pos_ind_o(pos_ind_o), .full_in_ind_o(full_in_ind_o), .full_out_ind_o(full_out_ind_o),
        .ac_feed_power_o(ac_feed_power_o), .dc_power_o(dc_power_o)
    );
    rgi_panel_model pnl (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .group_sel_i(group_sel_i),
        .aux_transfer_done_o(aux_transfer_done_i));
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // a hung run still reaches the verdict
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 1000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        {rst_n_i, auto_req_i, bypass_req_i, single_rod_sel_i, pos_src_rel_i} = '0;
        {group_sel_i, limit_in_i, limit_out_i, abs_pos_i, rel_pos_i, reg_avg_pos_i} = '0;
        {manual_cmd_i, auto_cmd_i, inhibit_i} = '0;
        trip_i = 6'h3f;
        safety_withdrawn_i = 8'h0f;
        step(5);
        chk("reset outputs", 16'h0000, {drive_cmd_o.withdraw, mode_o, ac_feed_power_o});
        step(5);
        rst_n_i = 1'b1;
        auto_req_i = 1'b1;
        auto_cmd_i.withdraw = 8'hff;
        for (int i = 0; i < 3; i++) begin
            reg_avg_pos_i[7:0] = pos_tab[i];
            step(3);
            chk("mode", rgi_pkg::RGI_MODE_AUTO, mode_o);
            chk("enables", en_tab[i], group_enable_o);
            chk("auto withdraw", en_tab[i], drive_cmd_o.withdraw);
            chk("under control", en_tab[i], under_control_o);
        end
        reg_avg_pos_i[15:8] = 8'h80;
        step(3);
        chk("pair out of step", 8'h00, drive_cmd_o.withdraw);
        reg_avg_pos_i[15:8] = 8'h00;
        inhibit_i.flux_out_inhibit = 1'b1;
        auto_cmd_i.insert = 8'hff;
        bypass_req_i = 1'b1;
        single_rod_sel_i = 1'b1;
        step(3);
        chk("flux withdraw", 8'h00, drive_cmd_o.withdraw);
        chk("auto insert", 8'h30, drive_cmd_o.insert);
        chk("bypass in auto", rgi_pkg::RGI_MODE_AUTO, mode_o);
        chk("single rod in auto", 1'b1, select_reject_o);
        $display("test auto done");
        single_rod_sel_i = 1'b0;
        inhibit_i = 3'b100;
        auto_req_i = 1'b0;
        auto_cmd_i = '0;
        step(3);
        chk("mode locked", rgi_pkg::RGI_MODE_AUTO, mode_o);
        chk("cmd inhibited", 16'h0000, drive_cmd_o);
        inhibit_i = '0;
        step(3);
        chk("bypass mode", rgi_pkg::RGI_MODE_BYPASS, mode_o);
        chk("bypass lamp", 1'b1, out_of_seq_ind_o);
        manual_cmd_i.withdraw = 8'h41;
        group_sel_i = 8'h41;
        step(3);
        chk("multi select", 9'h100, {select_reject_o, drive_cmd_o.withdraw});
        manual_cmd_i.withdraw = 8'h40;
        group_sel_i = 8'h40;
        single_rod_sel_i = 1'b1;
        step(3);
        chk("single select", 9'h040, {select_reject_o, drive_cmd_o.withdraw});
        $display("test bypass done");
        bypass_req_i = 1'b0;
        single_rod_sel_i = 1'b0;
        manual_cmd_i.withdraw = 8'h06;
        group_sel_i = 8'h06;
        step(3);
        chk("two safety", 8'h00, drive_cmd_o.withdraw);
        manual_cmd_i.withdraw = 8'h02;
        group_sel_i = 8'h02;
        auto_cmd_i = 16'hffff;
        step(3);
        chk("one safety", 16'h0002, drive_cmd_o);
        for (int i = 0; i < 5; i++) begin
            trip_i = trip_tab[i];
            step(2);
            chk("power", pw_tab[i], {ac_feed_power_o, dc_power_o});
            chk("trip gate", (&pw_tab[i]) ? 8'h02 : 8'h00, drive_cmd_o.withdraw);
        end
        $display("test trip done");
        abs_pos_i = 8'h5a;
        rel_pos_i = 8'ha5;
        limit_in_i = 8'h81;
        limit_out_i = 8'h7e;
        for (int i = 0; i < 2; i++) begin
            pos_src_rel_i = i[0];
            step(2);
            chk("indicator", i ? 8'ha5 : 8'h5a, pos_ind_o);
        end
        chk("limits", 16'h817e, {full_in_ind_o, full_out_ind_o});
        $display("test indication done");
        summarize();
    end
endmodule
bind rgi_interlock rgi_monitor mon (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .auto_req_i(auto_req_i),
    .bypass_req_i(bypass_req_i), .group_sel_i(group_sel_i), .manual_cmd_i(manual_cmd_i),
    .inhibit_i(inhibit_i), .trip_i(trip_i), .pos_src_rel_i(pos_src_rel_i),
    .abs_pos_i(abs_pos_i), .rel_pos_i(rel_pos_i), .limit_in_i(limit_in_i),
    .limit_out_i(limit_out_i), .drive_cmd_o(drive_cmd_o), .mode_o(mode_o),
    .select_reject_o(select_reject_o), .pos_ind_o(pos_ind_o), .full_in_ind_o(full_in_ind_o),
    .full_out_ind_o(full_out_ind_o), .ac_feed_power_o(ac_feed_power_o), .dc_power_o(dc_power_o)
);
